/* File: hw/rtu_map_regs.vh */
// Constants shared by the Modbus RTU slave front end and its character link.
// Assumes a 10 MHz system clock; counts are derived from CLK_HZ, the fast silence from CLK_PERIOD_NS.
`ifndef RTU_MAP_REGS_VH
`define RTU_MAP_REGS_VH

`define CLK_HZ          64'd10000000
`define CLK_PERIOD_NS   64'd100
`define BIT_CYC(b)      ((`CLK_HZ + (b) / 64'd2) / (b))
// Silence of 3.5 characters of 11 bits, rounded up to whole cycles.
`define SILENCE_CYC(b)  ((64'd385 * `CLK_HZ + 64'd10 * (b) - 64'd1) / (64'd10 * (b)))
`define T35_FAST_NS     64'd1750000
`define T35_FAST_CYC    ((`T35_FAST_NS + `CLK_PERIOD_NS - 64'd1) / `CLK_PERIOD_NS)

`define BAUD_9600       3'h0
`define BAUD_19200      3'h1
`define BAUD_38400      3'h2
`define BAUD_57600      3'h3
`define BAUD_115200     3'h4
`define PAR_NONE        2'h0
`define PAR_EVEN        2'h1
`define PAR_ODD         2'h2

`define PER_DEVICE_MAPPING              1'h0
`define SINGLE_ADDRESS_REGISTER_MAPPING 1'h1

`define DEF_BAUD        `BAUD_19200
`define DEF_PARITY      `PAR_EVEN
`define DEF_STATION     8'h01
`define DEF_MAP         `PER_DEVICE_MAPPING
`define DEF_EXPECTED    6'h01
`define ADDR_MIN        8'h01
`define ADDR_MAX        9'h0f7
`define MAX_UNITS       6'h32
`define REGS_PER_DEV    4'ha
`define MAX_QTY         16'h007d

`define FC_READ_HOLD    8'h03
`define FC_DIAG         8'h08
`define FC_EVT_CNT      8'h0b
`define FC_EVT_LOG      8'h0c
`define FC_SLAVE_ID     8'h11
`define FC_DEV_IDENT    8'h2b
`define EXC_FLAG        8'h80
`define EXC_FUNC        8'h01
`define EXC_ADDR        8'h02
`define EXC_VALUE       8'h03

// Station holding registers, by word index (register number minus one).
`define REG_DEVICE_TYPE    4'h0
`define REG_DEVICE_STATUS  4'h1
`define REG_EXPECTED       4'h2
`define REG_ONLINE_COUNT   4'h3
`define REG_FLAGS_1_16     4'h4
`define REG_FLAGS_17_32    4'h5
`define REG_FLAGS_33_48    4'h6
`define REG_FLAGS_49_50    4'h7
`define STATION_TYPE_VAL   16'h00ff
`define STATION_ONLINE_VAL 16'h0001

// Transmitter holding registers, by word index.
`define UREG_STATUS_LO     4'h3
`define UREG_PRIMARY_HI    4'h4
`define UREG_SECOND_HI     4'h6
`define UREG_SECOND_LO     4'h7
`define STATUS_ONLINE_BIT  1
`define NAN_HI             16'h7fc0
`define NAN_LO             16'h0000

`define CRC_INIT        16'hffff
`define CRC_POLY        16'ha001

`endif

/* File: hw/rtu_char_link.v */
// Serial character transmitter and receiver for the RS-485 line.
// Assumes rxd comes straight from a pin; it is synchronised here.
`timescale 1ns/1ps
`include "rtu_map_regs.vh"

module rtu_char_link (
  // Clock and reset
  input  wire        clock,
  input  wire        rst,
  // Line format
  input  wire [2:0]  baud_sel,
  input  wire [1:0]  parity_sel,
  // Line pins
  input  wire        rxd,
  output wire        txd,
  // Receive side
  output reg         rx_valid_r,
  output reg         rx_err_r,
  output reg  [7:0]  rx_data_r,
  output wire        rx_busy,
  // Transmit side
  input  wire        tx_start,
  input  wire [7:0]  tx_data,
  output wire        tx_busy
);

  localparam [63:0] D0 = `BIT_CYC(64'd9600);
  localparam [63:0] D1 = `BIT_CYC(64'd19200);
  localparam [63:0] D2 = `BIT_CYC(64'd38400);
  localparam [63:0] D3 = `BIT_CYC(64'd57600);
  localparam [63:0] D4 = `BIT_CYC(64'd115200);

  function [10:0] div_of;
    input [2:0] sel;
    begin
      case (sel)
        `BAUD_9600:  div_of = D0[10:0];
        `BAUD_19200: div_of = D1[10:0];
        `BAUD_38400: div_of = D2[10:0];
        `BAUD_57600: div_of = D3[10:0];
        default:     div_of = D4[10:0];
      endcase
    end
  endfunction

  // Bit after the data: parity when selected, else the first stop bit.
  function bit9_of;
    input [1:0] par;
    input [7:0] d;
    begin
      if (par == `PAR_EVEN)
        bit9_of = ^d;
      else if (par == `PAR_ODD)
        bit9_of = ~^d;
      else
        bit9_of = 1'b1;
    end
  endfunction

  wire [10:0] div = div_of(baud_sel);

  reg         rxd_m_r;
  reg         rxd_s_r;
  reg         rx_act_r;
  reg  [3:0]  rx_bit_r;
  reg  [10:0] rx_cnt_r;
  reg  [9:0]  rx_sh_r;
  reg  [10:0] tx_sh_r;
  reg  [3:0]  tx_bits_r;
  reg  [10:0] tx_cnt_r;
  reg         tx_busy_r;

  assign rx_busy = rx_act_r;
  assign tx_busy = tx_busy_r;
  assign txd     = tx_sh_r[0];

  always @(posedge clock) begin
    if (rst) begin
      rxd_m_r    <= 1'b1;
      rxd_s_r    <= 1'b1;
      rx_act_r   <= 1'b0;
      rx_bit_r   <= 4'h0;
      rx_cnt_r   <= 11'h000;
      rx_sh_r    <= 10'h000;
      rx_valid_r <= 1'b0;
      rx_err_r   <= 1'b0;
      rx_data_r  <= 8'h00;
    end else begin
      rxd_m_r    <= rxd;
      rxd_s_r    <= rxd_m_r;
      rx_valid_r <= 1'b0;
      rx_err_r   <= 1'b0;
      if (!rx_act_r) begin
        if (!rxd_s_r) begin
          rx_act_r <= 1'b1;
          rx_bit_r <= 4'h0;
          rx_cnt_r <= {1'b0, div[10:1]};
        end
      end else if (rx_cnt_r != 11'h000) begin
        rx_cnt_r <= rx_cnt_r - 11'h001;
      end else begin
        rx_cnt_r <= div - 11'h001;
        rx_bit_r <= rx_bit_r + 4'h1;
        rx_sh_r  <= {rxd_s_r, rx_sh_r[9:1]};
        if (rx_bit_r == 4'h0 && rxd_s_r) begin
          // A glitch shorter than half a bit is not a start bit.
          rx_act_r <= 1'b0;
        end else if (rx_bit_r == 4'ha) begin
          // Busy to mid stop bit: a low ninth bit is no start.
          rx_act_r  <= 1'b0;
        end else if (rx_bit_r == 4'h9) begin
          rx_data_r <= rx_sh_r[9:2];
          if (rxd_s_r == bit9_of(parity_sel, rx_sh_r[9:2]))
            rx_valid_r <= 1'b1;
          else
            rx_err_r <= 1'b1;
        end
      end
    end
  end

  always @(posedge clock) begin
    if (rst) begin
      tx_sh_r   <= 11'h7ff;
      tx_bits_r <= 4'h0;
      tx_cnt_r  <= 11'h000;
      tx_busy_r <= 1'b0;
    end else if (!tx_busy_r) begin
      if (tx_start) begin
        // Eleven bits always: parity plus one stop, or two stops.
        tx_sh_r   <= {1'b1, bit9_of(parity_sel, tx_data), tx_data, 1'b0};
        tx_bits_r <= 4'hb;
        tx_cnt_r  <= div - 11'h001;
        tx_busy_r <= 1'b1;
      end
    end else if (tx_cnt_r != 11'h000) begin
      tx_cnt_r <= tx_cnt_r - 11'h001;
    end else begin
      tx_cnt_r  <= div - 11'h001;
      tx_sh_r   <= {1'b1, tx_sh_r[10:1]};
      tx_bits_r <= tx_bits_r - 4'h1;
      if (tx_bits_r == 4'h1)
        tx_busy_r <= 1'b0;
    end
  end

endmodule

/* File: hw/modbus_rtu_slave_address_map.v */
// Modbus RTU slave front end: frame reception, address mapping and replies.
// Assumes radio-side logic on CLOCK supplies online flags and transmitter words.
// How it works
// - Single-address mode accepts station address 1 to 247 and serves everything there.
// - The station always answers at its configured slave address.
// - Per-device mode: transmitter answers at station address plus its radio identifier.
// - Per-device mode caps station address at 247 minus the transmitter count.
// - Per-device mode: ten holding registers at station and at each transmitter.
// - Single-address mode: station at 1-10, transmitter n at next blocks of ten.
// - Single-address mode serves transmitter data through function 03 at station address.
// - Characters: 8 data bits, even/odd/no parity, total of 11 bits.
// - Bit rate is one of 9600, 19200, 38400, 57600 or 115200.
// - Defaults: 19200 baud, 8 data bits, even parity, one stop bit.
// - Station slave address defaults to 1.
// - Mapping mode defaults to per-device mapping.
// - Only binary RTU framing is handled; ASCII is not.
// - Station register 4 reports the count of online transmitters.
// - Station registers 5 to 8 carry one online bit per transmitter.
// - Bit 1 of each transmitter status register shows its online state.
// - Offline transmitter returns NaN for primary and secondary measurements.
// - Single-measurement transmitter returns NaN for its secondary measurement.
// - Unsupported function codes get exception code 01, except 08, 0B, 0C, 11 and 2B, which raise DIAG_REQ and get no reply.
// - Invalid holding register addresses get exception code 02.
`timescale 1ns/1ps
`include "rtu_map_regs.vh"

module modbus_rtu_slave_address_map #(
  parameter [63:0] SIL_9600  = `SILENCE_CYC(64'd9600),
  parameter [63:0] SIL_19200 = `SILENCE_CYC(64'd19200),
  parameter [63:0] SIL_FAST  = `T35_FAST_CYC
) (
  // Clock and reset
  input  wire        CLOCK,
  input  wire        RST,
  // RS-485 line
  input  wire        RXD,
  output wire        TXD,
  output wire        TXEN,
  // Configuration
  input  wire        CFG_WRITE,
  input  wire [7:0]  CFG_STATION_SLAVE_ADDRESS,
  input  wire        CFG_MAPPING_MODE_SELECT,
  input  wire [2:0]  CFG_BAUD,
  input  wire [1:0]  CFG_PARITY,
  input  wire [5:0]  CFG_EXPECTED_TRANSMITTER_COUNT,
  output reg         CFG_REJECT,
  output reg  [7:0]  STATION_SLAVE_ADDRESS,
  output reg         MAPPING_MODE_SELECT,
  // Radio-side status and data
  input  wire [49:0] ONLINE,
  input  wire [49:0] SINGLE_MEAS,
  output reg  [5:0]  UNIT_SEL,
  output reg  [3:0]  WORD_SEL,
  input  wire [15:0] UNIT_WORD,
  // Observation
  output reg  [5:0]  ONLINE_COUNT,
  output reg         DIAG_REQ,
  output reg         FRAME_DROP
);

  localparam [2:0] S_RX    = 3'h0;
  localparam [2:0] S_CHECK = 3'h1;
  localparam [2:0] S_LOAD  = 3'h2;
  localparam [2:0] S_FETCH = 3'h3;
  localparam [2:0] S_SEND  = 3'h4;
  localparam [2:0] S_WAIT  = 3'h5;

  function [15:0] crc_step;
    input [15:0] c;
    input [7:0]  b;
    integer      i;
    reg   [15:0] x;
    begin
      x = c ^ {8'h00, b};
      for (i = 0; i < 8; i = i + 1)
        x = x[0] ? ((x >> 1) ^ `CRC_POLY) : (x >> 1);
      crc_step = x;
    end
  endfunction

  function [5:0] pop50;
    input [49:0] v;
    integer      i;
    begin
      pop50 = 6'h00;
      for (i = 0; i < 50; i = i + 1)
        pop50 = pop50 + {5'h00, v[i]};
    end
  endfunction

  reg [2:0]  baud_r;
  reg [1:0]  parity_r;
  reg [5:0]  expected_transmitter_count_r;
  reg [2:0]  state_r;
  reg [7:0]  buf_r [0:7];
  reg [3:0]  nbytes_r;
  reg        bad_r;
  reg [19:0] sil_r;
  reg [15:0] rx_crc_r;
  reg [15:0] tx_crc_r;
  reg        exc_r;
  reg [7:0]  exc_code_r;
  reg [7:0]  len_r;
  reg [7:0]  idx_r;
  reg [7:0]  byte_r;
  reg [15:0] data_word_r;

  wire       rx_valid;
  wire       rx_err;
  wire [7:0] rx_data;
  wire       rx_busy;
  wire       tx_busy;
  wire       tx_start = (state_r == S_SEND) && !tx_busy;

  rtu_char_link link (
    .clock      (CLOCK),
    .rst        (RST),
    .baud_sel   (baud_r),
    .parity_sel (parity_r),
    .rxd        (RXD),
    .txd        (TXD),
    .rx_valid_r (rx_valid),
    .rx_err_r   (rx_err),
    .rx_data_r  (rx_data),
    .rx_busy    (rx_busy),
    .tx_start   (tx_start),
    .tx_data    (byte_r),
    .tx_busy    (tx_busy)
  );

  assign TXEN = (state_r != S_RX) && (state_r != S_CHECK);

  // Configuration checks; a rejected write leaves every setting as it was.
  wire [8:0] cfg_top   = {1'b0, CFG_STATION_SLAVE_ADDRESS} + {3'h0, CFG_EXPECTED_TRANSMITTER_COUNT};
  wire       cfg_ok    = (CFG_STATION_SLAVE_ADDRESS >= `ADDR_MIN) &&
                         ({1'b0, CFG_STATION_SLAVE_ADDRESS} <= `ADDR_MAX) &&
                         (CFG_MAPPING_MODE_SELECT == `SINGLE_ADDRESS_REGISTER_MAPPING ||
                          cfg_top <= `ADDR_MAX) &&
                         (CFG_BAUD <= `BAUD_115200) &&
                         (CFG_PARITY <= `PAR_ODD) &&
                         (CFG_EXPECTED_TRANSMITTER_COUNT <= `MAX_UNITS);

  always @(posedge CLOCK) begin
    if (RST) begin
      baud_r                       <= `DEF_BAUD;
      parity_r                     <= `DEF_PARITY;
      STATION_SLAVE_ADDRESS        <= `DEF_STATION;
      MAPPING_MODE_SELECT          <= `DEF_MAP;
      expected_transmitter_count_r <= `DEF_EXPECTED;
      CFG_REJECT                   <= 1'b0;
      ONLINE_COUNT                 <= 6'h00;
    end else begin
      CFG_REJECT   <= CFG_WRITE && !cfg_ok;
      ONLINE_COUNT <= pop50(ONLINE);
      if (CFG_WRITE && cfg_ok) begin
        baud_r                       <= CFG_BAUD;
        parity_r                     <= CFG_PARITY;
        STATION_SLAVE_ADDRESS        <= CFG_STATION_SLAVE_ADDRESS;
        MAPPING_MODE_SELECT          <= CFG_MAPPING_MODE_SELECT;
        expected_transmitter_count_r <= CFG_EXPECTED_TRANSMITTER_COUNT;
      end
    end
  end

  // Frame end is RTU line silence; there is no ASCII delimiter detection.
  reg [19:0] sil_lim;
  always @* begin
    if (baud_r == `BAUD_9600)
      sil_lim = SIL_9600[19:0];
    else if (baud_r == `BAUD_19200)
      sil_lim = SIL_19200[19:0];
    else
      sil_lim = SIL_FAST[19:0];
  end
  wire frame_end = (state_r == S_RX) && (nbytes_r != 4'h0) && (sil_r >= sil_lim);

  // Request decode.
  wire [7:0]  rq_addr  = buf_r[0];
  wire [7:0]  rq_func  = buf_r[1];
  wire [15:0] rq_start = {buf_r[2], buf_r[3]};
  wire [15:0] rq_qty   = {buf_r[4], buf_r[5]};
  wire [7:0]  diff     = rq_addr - STATION_SLAVE_ADDRESS;
  wire        per_dev  = (MAPPING_MODE_SELECT == `PER_DEVICE_MAPPING);
  wire        hit_stn  = (rq_addr == STATION_SLAVE_ADDRESS);
  wire        hit_unit = per_dev && (rq_addr > STATION_SLAVE_ADDRESS) &&
                         (diff <= {2'h0, expected_transmitter_count_r});
  wire [9:0]  limit    = per_dev ? {6'h00, `REGS_PER_DEV} :
                         10'd10 * ({4'h0, expected_transmitter_count_r} + 10'h001);
  wire [16:0] rq_end   = {1'b0, rq_start} + {1'b0, rq_qty};
  wire        other_fc = (rq_func == `FC_DIAG) || (rq_func == `FC_EVT_CNT) ||
                         (rq_func == `FC_EVT_LOG) || (rq_func == `FC_SLAVE_ID) ||
                         (rq_func == `FC_DEV_IDENT);
  wire        intact   = !bad_r && (nbytes_r >= 4'h4) && (rx_crc_r == 16'h0000);
  wire [8:0]  blk      = rq_start[8:0] / 9'd10;
  wire [8:0]  blk_word = rq_start[8:0] - blk * 9'd10;

  // Word to send for the current unit and word pointer.
  wire       u_on     = ONLINE[UNIT_SEL - 6'h01];
  wire       u_single = SINGLE_MEAS[UNIT_SEL - 6'h01];
  reg [15:0] word_val;
  always @* begin
    word_val = UNIT_WORD;
    if (UNIT_SEL == 6'h00) begin
      case (WORD_SEL)
        `REG_DEVICE_TYPE:   word_val = `STATION_TYPE_VAL;
        `REG_DEVICE_STATUS: word_val = `STATION_ONLINE_VAL;
        `REG_EXPECTED:      word_val = {10'h000, expected_transmitter_count_r};
        `REG_ONLINE_COUNT:  word_val = {10'h000, ONLINE_COUNT};
        `REG_FLAGS_1_16:    word_val = ONLINE[15:0];
        `REG_FLAGS_17_32:   word_val = ONLINE[31:16];
        `REG_FLAGS_33_48:   word_val = ONLINE[47:32];
        `REG_FLAGS_49_50:   word_val = {14'h0000, ONLINE[49:48]};
        default:            word_val = 16'h0000;
      endcase
    end else if (WORD_SEL >= `UREG_PRIMARY_HI && WORD_SEL <= `UREG_SECOND_LO && !u_on) begin
      word_val = WORD_SEL[0] ? `NAN_LO : `NAN_HI;
    end else if (WORD_SEL >= `UREG_SECOND_HI && WORD_SEL <= `UREG_SECOND_LO && u_single) begin
      word_val = WORD_SEL[0] ? `NAN_LO : `NAN_HI;
    end else if (WORD_SEL == `UREG_STATUS_LO) begin
      word_val[`STATUS_ONLINE_BIT] = u_on;
    end
  end

  wire [7:0] data_pos = idx_r - 8'h03;

  always @(posedge CLOCK) begin
    if (RST) begin
      state_r     <= S_RX;
      nbytes_r    <= 4'h0;
      bad_r       <= 1'b0;
      sil_r       <= 20'h00000;
      rx_crc_r    <= `CRC_INIT;
      tx_crc_r    <= `CRC_INIT;
      exc_r       <= 1'b0;
      exc_code_r  <= 8'h00;
      len_r       <= 8'h00;
      idx_r       <= 8'h00;
      byte_r      <= 8'h00;
      data_word_r <= 16'h0000;
      UNIT_SEL    <= 6'h00;
      WORD_SEL    <= 4'h0;
      DIAG_REQ    <= 1'b0;
      FRAME_DROP  <= 1'b0;
    end else begin
      DIAG_REQ   <= 1'b0;
      FRAME_DROP <= 1'b0;
      case (state_r)
        S_RX: begin
          if (rx_busy || rx_valid || rx_err)
            sil_r <= 20'h00000;
          else if (sil_r != 20'hfffff)
            sil_r <= sil_r + 20'h00001;
          if (rx_valid) begin
            if (nbytes_r < 4'h8)
              buf_r[nbytes_r[2:0]] <= rx_data;
            if (nbytes_r != 4'hf)
              nbytes_r <= nbytes_r + 4'h1;
            rx_crc_r <= crc_step(rx_crc_r, rx_data);
          end
          if (rx_err)
            bad_r <= 1'b1;
          if (frame_end)
            state_r <= S_CHECK;
        end
        S_CHECK: begin
          idx_r    <= 8'h00;
          tx_crc_r <= `CRC_INIT;
          exc_r    <= 1'b1;
          len_r    <= 8'h05;
          state_r  <= S_LOAD;
          if (per_dev && hit_unit) begin
            UNIT_SEL <= diff[5:0];
            WORD_SEL <= rq_start[3:0];
          end else begin
            UNIT_SEL <= blk[5:0];
            WORD_SEL <= per_dev ? rq_start[3:0] : blk_word[3:0];
          end
          if (!intact) begin
            FRAME_DROP <= 1'b1;
            state_r    <= S_RX;
          end else if (!hit_stn && !hit_unit) begin
            state_r <= S_RX;
          end else if (other_fc) begin
            DIAG_REQ <= 1'b1;
            state_r  <= S_RX;
          end else if (rq_func != `FC_READ_HOLD) begin
            exc_code_r <= `EXC_FUNC;
          end else if (nbytes_r != 4'h8) begin
            FRAME_DROP <= 1'b1;
            state_r    <= S_RX;
          end else if (rq_qty == 16'h0000 || rq_qty > `MAX_QTY) begin
            exc_code_r <= `EXC_VALUE;
          end else if (rq_end > {7'h00, limit}) begin
            exc_code_r <= `EXC_ADDR;
          end else begin
            exc_r <= 1'b0;
            len_r <= {rq_qty[6:0], 1'b0} + 8'h05;
          end
        end
        S_LOAD: begin
          state_r <= S_SEND;
          if (idx_r == 8'h00)
            byte_r <= rq_addr;
          else if (idx_r == 8'h01)
            byte_r <= exc_r ? (rq_func | `EXC_FLAG) : rq_func;
          else if (idx_r == 8'h02)
            byte_r <= exc_r ? exc_code_r : {rq_qty[6:0], 1'b0};
          else if (idx_r == len_r - 8'h02)
            byte_r <= tx_crc_r[7:0];
          else if (idx_r == len_r - 8'h01)
            byte_r <= tx_crc_r[15:8];
          else if (!data_pos[0])
            state_r <= S_FETCH;
          else begin
            byte_r <= data_word_r[7:0];
            if (WORD_SEL == `REGS_PER_DEV - 4'h1) begin
              WORD_SEL <= 4'h0;
              UNIT_SEL <= UNIT_SEL + 6'h01;
            end else begin
              WORD_SEL <= WORD_SEL + 4'h1;
            end
          end
        end
        S_FETCH: begin
          data_word_r <= word_val;
          byte_r      <= word_val[15:8];
          state_r     <= S_SEND;
        end
        S_SEND: begin
          if (!tx_busy) begin
            if (idx_r < len_r - 8'h02)
              tx_crc_r <= crc_step(tx_crc_r, byte_r);
            state_r  <= S_WAIT;
          end
        end
        default: begin
          if (!tx_busy) begin
            idx_r   <= idx_r + 8'h01;
            state_r <= (idx_r == len_r - 8'h01) ? S_RX : S_LOAD;
          end
        end
      endcase
      if (state_r == S_CHECK) begin
        nbytes_r <= 4'h0;
        bad_r    <= 1'b0;
        sil_r    <= 20'h00000;
        rx_crc_r <= `CRC_INIT;
      end
    end
  end

endmodule

/* File: hw/dummy_never.v */
`timescale 1ns/1ps

/* File: dv/rtu_host_model.sv */
// Host master model: sends characters to the slave and collects its reply characters.
// Assumes 11-bit characters, LSB first, and a bit time of BIT clock cycles.
`timescale 1ns/1ps

module rtu_host_model #(
  parameter int BIT = 87
) (
  // Line
  input  wire logic clock,
  output logic      txd,
  input  wire logic rxd,
  input  wire logic txen
);
  logic [1:0] par = 2'h2;
  logic [7:0] rq[$];
  int         perr = 0;
  logic [8:0] c9;

  initial txd = 1'b1;

  // Binary characters only, 8 data bits, parity or second stop bit, then stop.
  task automatic put(input logic [7:0] b);
    logic [10:0] c;
    c = {1'b1, (par == 2'h0) ? 1'b1 : (^b ^ par[1]), b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      txd = c[i];
      repeat (BIT) @(posedge clock);
      #1;
    end
  endtask

  // Samples each reply character at mid-bit and checks its ninth bit.
  initial forever begin
    @(negedge rxd);
    if (txen) begin
      repeat (BIT / 2) @(posedge clock);
      for (int i = 0; i < 9; i++) begin
        repeat (BIT) @(posedge clock);
        c9[i] = rxd;
      end
      rq.push_back(c9[7:0]);
      if (c9[8] !== ((par == 2'h0) ? 1'b1 : (^c9[7:0] ^ par[1]))) perr++;
      repeat (BIT) @(posedge clock);
    end
  end
endmodule

/* File: dv/rtu_map_checker_assertions.sv */
// Port checks for the slave front end.
// Assumes one clock domain with synchronous active-high reset.
`timescale 1ns/1ps

module rtu_map_checker (
  // Clock and reset
  input wire logic        CLOCK,
  input wire logic        RST,
  // Line and configuration
  input wire logic        TXD,
  input wire logic        TXEN,
  input wire logic        CFG_WRITE,
  input wire logic [7:0]  CFG_STATION_SLAVE_ADDRESS,
  input wire logic        CFG_MAPPING_MODE_SELECT,
  input wire logic [5:0]  CFG_EXPECTED_TRANSMITTER_COUNT,
  input wire logic        CFG_REJECT,
  input wire logic [7:0]  STATION_SLAVE_ADDRESS,
  input wire logic        MAPPING_MODE_SELECT,
  // Radio status
  input wire logic [49:0] ONLINE,
  input wire logic [5:0]  ONLINE_COUNT
);
  default clocking dc @(posedge CLOCK); endclocking
  default disable iff (RST);

  line_idle_a: assert property (!TXEN |-> TXD)
    else $error("line not idle while driver off");
  start_bit_a: assert property ($rose(TXEN) |-> ##[1:5] !TXD)
    else $error("no start bit after driver on");
  bad_addr_a: assert property (CFG_WRITE && (CFG_STATION_SLAVE_ADDRESS == 8'h00 ||
    CFG_STATION_SLAVE_ADDRESS > 8'hf7) |=> CFG_REJECT) else $error("bad address taken");
  addr_cap_a: assert property (CFG_WRITE && !CFG_MAPPING_MODE_SELECT &&
    9'(CFG_STATION_SLAVE_ADDRESS) + 9'(CFG_EXPECTED_TRANSMITTER_COUNT) > 9'h0f7 |=> CFG_REJECT)
    else $error("address ceiling not enforced");
  reject_hold_a: assert property (CFG_REJECT |-> $stable(STATION_SLAVE_ADDRESS) && $stable(MAPPING_MODE_SELECT))
    else $error("refused write changed settings");
  reject_cause_a: assert property (CFG_REJECT |-> $past(CFG_WRITE))
    else $error("reject without a write");
  reset_dflt_a: assert property ($past(RST) |-> STATION_SLAVE_ADDRESS == 8'h01 && !MAPPING_MODE_SELECT)
    else $error("wrong settings after reset");
  online_cnt_a: assert property (!$past(RST) |-> ONLINE_COUNT == 6'($countones($past(ONLINE))))
    else $error("online count wrong");
  settings_hold_a: assert property (!CFG_WRITE |=> $stable(MAPPING_MODE_SELECT) && $stable(STATION_SLAVE_ADDRESS))
    else $error("settings changed without a write");

  cover property (CFG_REJECT);
  cover property ($rose(TXEN));
  cover property ($rose(MAPPING_MODE_SELECT));
endmodule

/* File: dv/test_modbus_rtu_slave_address_map.sv */
// Self-checking bench for the slave front end at 115200 baud.
// Assumes the host model and the port checker from this folder.
`timescale 1ns/1ps

module test_modbus_rtu_slave_address_map;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        cfg_write = 1'b0;
  logic [7:0]  cfg_addr = 8'h01;
  logic        cfg_mode = 1'b0;
  logic [2:0]  cfg_baud = 3'h1;
  logic [1:0]  cfg_par = 2'h1;
  logic [5:0]  cfg_cnt = 6'h01;
  logic [49:0] online = 50'h2_0000_0001_0002;
  logic [49:0] single = 50'h2;
  wire  [5:0]  unit_sel;
  wire  [3:0]  word_sel;
  wire  [15:0] unit_word = {unit_sel, word_sel, 2'h0, ~unit_sel[3:0]};
  wire         rxd, txd, txen, cfg_reject, mode;
  wire  [7:0]  addr;
  int          errors = 0;
  int          checked = 0;
  int          cycles = 0;
  logic [7:0]  cur = 8'h01;
  logic [7:0]  rq[$];
  logic [7:0]  ex[$];

  // Short silence keeps the run brief; it still exceeds four bit times.
  modbus_rtu_slave_address_map #(.SIL_FAST(64'd400)) DUT (
    .CLOCK(clock), .RST(rst), .RXD(rxd), .TXD(txd), .TXEN(txen), .CFG_WRITE(cfg_write),
    .CFG_STATION_SLAVE_ADDRESS(cfg_addr), .CFG_MAPPING_MODE_SELECT(cfg_mode), .CFG_BAUD(cfg_baud),
    .CFG_PARITY(cfg_par), .CFG_EXPECTED_TRANSMITTER_COUNT(cfg_cnt), .CFG_REJECT(cfg_reject),
    .STATION_SLAVE_ADDRESS(addr), .MAPPING_MODE_SELECT(mode), .ONLINE(online), .SINGLE_MEAS(single),
    .UNIT_SEL(unit_sel), .WORD_SEL(word_sel), .UNIT_WORD(unit_word), .ONLINE_COUNT(), .DIAG_REQ(),
    .FRAME_DROP());

  rtu_host_model #(.BIT(87)) H (.clock(clock), .txd(rxd), .rxd(txd), .txen(txen));

  initial forever #50 clock = ~clock;

  task automatic finish_test();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask

  function automatic logic [15:0] crc(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (q[i]) begin
      c = c ^ {8'h0, q[i]};
      repeat (8) c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
    end
    return c;
  endfunction

  function automatic logic [15:0] uw(input logic [5:0] u, input logic [3:0] w);
    return {u, w, 2'h0, ~u[3:0]};
  endfunction

  function automatic void w(input logic [15:0] v);
    ex.push_back(v[15:8]);
    ex.push_back(v[7:0]);
  endfunction

  task automatic cfg(input logic [7:0] a, input logic m, input logic [2:0] b, input logic [1:0] p,
                     input logic [5:0] n, input logic rej);
    @(posedge clock);
    #1;
    {cfg_addr, cfg_mode, cfg_baud, cfg_par, cfg_cnt, cfg_write} = {a, m, b, p, n, 1'b1};
    @(posedge clock);
    #1;
    cfg_write = 1'b0;
    if (!rej) cur = a;
    chk("reject", {15'h0, rej}, {15'h0, cfg_reject});
    chk("address", {8'h0, cur}, {8'h0, addr});
    if (!rej) chk("mode", {15'h0, m}, {15'h0, mode});
  endtask

  // Sends rq with its CRC and compares the whole reply, CRC included, with ex.
  task automatic xact();
    logic [15:0] c;
    c = crc(rq);
    rq.push_back(c[7:0]);
    rq.push_back(c[15:8]);
    if (ex.size() != 0) begin
      c = crc(ex);
      ex.push_back(c[7:0]);
      ex.push_back(c[15:8]);
    end
    H.rq.delete();
    foreach (rq[i]) H.put(rq[i]);
    for (int k = 0; k < 20000 && (H.rq.size() < ex.size() || k < 1500); k++) @(posedge clock);
    while (txen) @(posedge clock);
    #1;
    chk("length", 16'(ex.size()), 16'(H.rq.size()));
    foreach (ex[i]) if (i < H.rq.size()) chk("byte", {8'h0, ex[i]}, {8'h0, H.rq[i]});
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 100000) begin
      errors++;
      finish_test();
    end
  end

  initial begin
    repeat (10) @(posedge clock);
    #1;
    rst = 1'b0;
    chk("address", 16'h0001, {8'h0, addr});
    chk("mode", 16'h0000, {15'h0, mode});
    cfg(8'h00, 1'b1, 3'h4, 2'h2, 6'h08, 1'b1);
    cfg(8'hf7, 1'b1, 3'h4, 2'h2, 6'h08, 1'b0);
    cfg(8'hf8, 1'b1, 3'h4, 2'h2, 6'h08, 1'b1);
    cfg(8'hf0, 1'b0, 3'h4, 2'h2, 6'h08, 1'b1);
    cfg(8'hef, 1'b0, 3'h4, 2'h2, 6'h08, 1'b0);
    cfg(8'h0a, 1'b0, 3'h5, 2'h2, 6'h08, 1'b1);
    cfg(8'h0a, 1'b0, 3'h4, 2'h3, 6'h08, 1'b1);
    cfg(8'h0a, 1'b0, 3'h4, 2'h2, 6'h08, 1'b0);
    // Transmitter 5 is offline: status bit cleared and measurements not-a-number.
    rq = {8'h0f, 8'h03, 8'h00, 8'h03, 8'h00, 8'h04};
    ex = {8'h0f, 8'h03, 8'h08};
    w(uw(6'd5, 4'h3) & 16'hfffd);
    w(16'h7fc0);
    w(16'h0000);
    w(16'h7fc0);
    xact();
    rq = {8'h13, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01};
    ex = {};
    xact();
    rq = {8'h0a, 8'h03, 8'h00, 8'h09, 8'h00, 8'h02};
    ex = {8'h0a, 8'h83, 8'h02};
    xact();
    cfg(8'h0a, 1'b1, 3'h4, 2'h2, 6'h08, 1'b0);
    rq = {8'h0a, 8'h03, 8'h00, 8'h03, 8'h00, 8'h05};
    ex = {8'h0a, 8'h03, 8'h0a};
    w(16'($countones(online)));
    w(online[15:0]);
    w(online[31:16]);
    w(online[47:32]);
    w({14'h0, online[49:48]});
    xact();
    // Transmitter 2 is online and measures one quantity.
    rq = {8'h0a, 8'h03, 8'h00, 8'h17, 8'h00, 8'h04};
    ex = {8'h0a, 8'h03, 8'h08};
    w(uw(6'd2, 4'h3) | 16'h0002);
    w(uw(6'd2, 4'h4));
    w(uw(6'd2, 4'h5));
    w(16'h7fc0);
    xact();
    cfg(8'h0a, 1'b1, 3'h4, 2'h0, 6'h08, 1'b0);
    H.par = 2'h0;
    rq = {8'h0a, 8'h06};
    ex = {8'h0a, 8'h86, 8'h01};
    xact();
    chk("parity", 16'h0000, 16'(H.perr));
    finish_test();
  end
endmodule

bind modbus_rtu_slave_address_map rtu_map_checker CHK (.CLOCK(CLOCK), .RST(RST), .TXD(TXD), .TXEN(TXEN),
  .CFG_WRITE(CFG_WRITE), .CFG_STATION_SLAVE_ADDRESS(CFG_STATION_SLAVE_ADDRESS),
  .CFG_MAPPING_MODE_SELECT(CFG_MAPPING_MODE_SELECT), .CFG_EXPECTED_TRANSMITTER_COUNT(CFG_EXPECTED_TRANSMITTER_COUNT),
  .CFG_REJECT(CFG_REJECT), .STATION_SLAVE_ADDRESS(STATION_SLAVE_ADDRESS), .MAPPING_MODE_SELECT(MAPPING_MODE_SELECT),
  .ONLINE(ONLINE), .ONLINE_COUNT(ONLINE_COUNT));
